/* File: rtl/uocsr_stat_fifo.sv */
// Purpose: Four-entry transaction status FIFO, head exposed to software
// Assumes: Push and pop are one-cycle pulses
// Notes: Push when full is dropped; flops addressed by index
module uocsr_stat_fifo #(
  parameter int DEPTH = uocsr_pkg::FIFO_DEPTH
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic clear,
  input wire logic push,
  input uocsr_pkg::uocsr_stat_t push_data,
  input wire logic pop,
  output uocsr_pkg::uocsr_stat_t head,
  output logic not_empty,
  output logic full
);
  localparam int AW = $clog2(DEPTH);
  uocsr_pkg::uocsr_stat_t mem_ff [DEPTH];
  logic [AW-1:0] rd_ff;
  logic [AW-1:0] wr_ff;
  logic [AW:0] cnt_ff;
  logic do_push;
  logic do_pop;

  assign full = (cnt_ff == (AW+1)'(DEPTH));
  assign not_empty = (cnt_ff != '0);
  assign do_push = push && !full;
  assign do_pop = pop && not_empty;
  assign head = mem_ff[rd_ff];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_ff[i] <= '0;
      end
    end else if (do_push) begin
      mem_ff[wr_ff] <= push_data;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_ff <= '0;
      wr_ff <= '0;
      cnt_ff <= '0;
    end else if (clear) begin
      rd_ff <= '0;
      wr_ff <= '0;
      cnt_ff <= '0;
    end else begin
      if (do_push) begin
        wr_ff <= wr_ff + 1'b1;
      end
      if (do_pop) begin
        rd_ff <= rd_ff + 1'b1;
      end
      cnt_ff <= cnt_ff + (AW+1)'(do_push) - (AW+1)'(do_pop);
    end
  end
endmodule

/* File: rtl/uocsr_top.sv */
// Purpose: USB OTG control and status register slice behind an AHB-Lite slave
// Assumes: Link engine supplies event pulses and live line states on hclk
// Notes: Zero-wait-state slave, every response OKAY
module uocsr_top #(
  parameter int SOF_CYCLES = uocsr_pkg::SOF_CYCLES
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic [7:0] err_events,
  input wire logic trn_done,
  input uocsr_pkg::uocsr_stat_t trn_stat,
  input wire logic setup_rx,
  input wire logic token_active,
  input wire logic sof_rx,
  input wire logic [10:0] sof_frame,
  input wire logic line_j,
  input wire logic line_se0,
  output logic module_irq_flag,
  output logic module_on,
  output logic host_logic_rst,
  output logic bus_reset_drive,
  output logic resume_drive,
  output logic ls_eop_drive,
  output logic pingpong_pointer_reset,
  output logic packet_proc_disable,
  output logic sof_send,
  output logic next_token_low_speed,
  output logic [6:0] function_address,
  output logic stat_fifo_full
);
  uocsr_pkg::uocsr_req_t req_ff;
  uocsr_pkg::uocsr_stat_t head;
  logic [7:0] err_en_ff;
  logic [7:0] err_flag_ff;
  logic [7:0] irq_en_ff;
  logic [7:0] irq_flag_ff;
  logic [5:0] ctrl_ff;
  logic [7:0] addr_ff;
  logic [10:0] frame_ff;
  logic [31:0] rdata_ff;
  logic [$clog2(uocsr_pkg::LS_EOP_CYCLES+1)-1:0] eop_cnt_ff;
  logic [$clog2(SOF_CYCLES)-1:0] sof_cnt_ff;
  logic host_ff;
  logic sof_ff;
  logic fifo_ne;
  logic wr_en;
  logic [7:0] wb;
  logic host_mode;
  logic err_any;
  logic trn_clr;
  logic hostt_tog;

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = rdata_ff;
  assign wr_en = req_ff.htrans == uocsr_pkg::HTRANS_NONSEQ && req_ff.write && req_ff.ok_size;
  assign wb = hwdata[7:0];
  assign host_mode = ctrl_ff[uocsr_pkg::CTRL_HOST];
  assign module_on = !host_mode && ctrl_ff[uocsr_pkg::CTRL_ON];
  assign bus_reset_drive = host_mode && ctrl_ff[uocsr_pkg::CTRL_BRST];
  assign resume_drive = ctrl_ff[uocsr_pkg::CTRL_RES];
  assign ls_eop_drive = eop_cnt_ff != '0;
  assign pingpong_pointer_reset = ctrl_ff[uocsr_pkg::CTRL_PPRST];
  assign packet_proc_disable = !host_mode && ctrl_ff[uocsr_pkg::CTRL_PKT];
  assign sof_send = sof_ff;
  assign next_token_low_speed = addr_ff[7];
  assign function_address = addr_ff[6:0];
  assign hostt_tog = wr_en && req_ff.addr == uocsr_pkg::OFS_CTRL
    && wb[uocsr_pkg::CTRL_HOST] != host_mode;
  assign host_logic_rst = host_ff;
  assign err_any = |(err_flag_ff & err_en_ff);
  assign module_irq_flag = |(irq_flag_ff & irq_en_ff);
  assign trn_clr = wr_en && req_ff.addr == uocsr_pkg::OFS_IRQ_FLAG && wb[uocsr_pkg::IRQ_TRN];

  uocsr_stat_fifo #(
    .DEPTH(uocsr_pkg::FIFO_DEPTH)
  ) u_fifo (
    .hclk(hclk),
    .hresetn(hresetn),
    .clear(1'b0),
    .push(trn_done),
    .push_data(trn_stat),
    .pop(trn_clr && irq_flag_ff[uocsr_pkg::IRQ_TRN]),
    .head(head),
    .not_empty(fifo_ne),
    .full(stat_fifo_full)
  );

  // Address phase capture
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      req_ff <= '0;
    end else if (hready) begin
      req_ff.htrans <= hsel ? htrans : 2'h0;
      req_ff.addr <= haddr[7:0] & uocsr_pkg::OFS_MASK;
      req_ff.write <= hwrite;
      req_ff.ok_size <= hsize == uocsr_pkg::HSIZE_WORD;
    end
  end

  // Read data registered at address phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rdata_ff <= '0;
    end else if (hready && hsel && htrans == uocsr_pkg::HTRANS_NONSEQ && !hwrite) begin
      unique case (haddr[7:0] & uocsr_pkg::OFS_MASK)
        uocsr_pkg::OFS_ERR_EN: rdata_ff <= {24'h0, err_en_ff};
        uocsr_pkg::OFS_STAT: rdata_ff <= {24'h0, head, 2'h0};
        uocsr_pkg::OFS_CTRL: rdata_ff <= {24'h0, line_j, line_se0,
          host_mode ? token_active : ctrl_ff[uocsr_pkg::CTRL_PKT],
          ctrl_ff[4:0]};
        uocsr_pkg::OFS_ADDR: rdata_ff <= {24'h0, addr_ff};
        uocsr_pkg::OFS_FRML: rdata_ff <= {24'h0, frame_ff[7:0]};
        uocsr_pkg::OFS_FRMH: rdata_ff <= {29'h0, frame_ff[10:8]};
        uocsr_pkg::OFS_IRQ_EN: rdata_ff <= {24'h0, irq_en_ff};
        uocsr_pkg::OFS_IRQ_FLAG: rdata_ff <= {24'h0, irq_flag_ff};
        uocsr_pkg::OFS_ERR_FLAG: rdata_ff <= {24'h0, err_flag_ff};
        default: rdata_ff <= '0;
      endcase
    end
  end

  // Software-written enables and address
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      err_en_ff <= uocsr_pkg::BYTE_ZERO;
      irq_en_ff <= uocsr_pkg::BYTE_ZERO;
      addr_ff <= uocsr_pkg::BYTE_ZERO;
    end else if (wr_en) begin
      if (req_ff.addr == uocsr_pkg::OFS_ERR_EN) begin
        err_en_ff <= wb;
      end
      if (req_ff.addr == uocsr_pkg::OFS_IRQ_EN) begin
        irq_en_ff <= wb;
      end
      if (req_ff.addr == uocsr_pkg::OFS_ADDR) begin
        addr_ff <= wb;
      end
    end
  end

  // Error flags: write one to clear, set wins
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      err_flag_ff <= uocsr_pkg::BYTE_ZERO;
    end else begin
      err_flag_ff <= (err_flag_ff & ~((wr_en && req_ff.addr == uocsr_pkg::OFS_ERR_FLAG)
        ? wb : uocsr_pkg::BYTE_ZERO)) | err_events;
    end
  end

  // Interrupt flags; error bit mirrors unmasked errors, transaction bit tracks FIFO
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_flag_ff <= uocsr_pkg::BYTE_ZERO;
    end else begin
      for (int i = 0; i < 8; i++) begin
        if (i == uocsr_pkg::IRQ_ERR) begin
          irq_flag_ff[i] <= err_any;
        end else if (i == uocsr_pkg::IRQ_TRN) begin
          irq_flag_ff[i] <= trn_clr ? (trn_done || (fifo_ne && !irq_flag_ff[i]))
            : (irq_flag_ff[i] || trn_done || fifo_ne);
        end else begin
          irq_flag_ff[i] <= 1'b0;
        end
      end
    end
  end

  // Control register with hardware-set packet disable
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_ff <= '0;
    end else begin
      if (wr_en && req_ff.addr == uocsr_pkg::OFS_CTRL) begin
        ctrl_ff <= wb[5:0];
      end
      if (setup_rx && !host_mode) begin
        ctrl_ff[uocsr_pkg::CTRL_PKT] <= 1'b1;
      end
    end
  end

  // Host control reset pulse on each toggle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      host_ff <= 1'b0;
    end else begin
      host_ff <= hostt_tog;
    end
  end

  // Low-speed end-of-packet after resume drops in host mode
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      eop_cnt_ff <= '0;
    end else if (host_ff) begin
      eop_cnt_ff <= '0;
    end else if (host_mode && wr_en && req_ff.addr == uocsr_pkg::OFS_CTRL
        && ctrl_ff[uocsr_pkg::CTRL_RES] && !wb[uocsr_pkg::CTRL_RES]) begin
      eop_cnt_ff <= ($bits(eop_cnt_ff))'(uocsr_pkg::LS_EOP_CYCLES);
    end else if (eop_cnt_ff != '0) begin
      eop_cnt_ff <= eop_cnt_ff - 1'b1;
    end
  end

  // One-millisecond SOF timer in host mode
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sof_cnt_ff <= '0;
      sof_ff <= 1'b0;
    end else if (!host_mode || !ctrl_ff[uocsr_pkg::CTRL_ON] || host_ff) begin
      sof_cnt_ff <= '0;
      sof_ff <= 1'b0;
    end else begin
      sof_ff <= sof_cnt_ff == ($bits(sof_cnt_ff))'(SOF_CYCLES - 1);
      if (sof_cnt_ff == ($bits(sof_cnt_ff))'(SOF_CYCLES - 1)) begin
        sof_cnt_ff <= '0;
      end else begin
        sof_cnt_ff <= sof_cnt_ff + 1'b1;
      end
    end
  end

  // Frame number capture
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      frame_ff <= '0;
    end else if (sof_rx) begin
      frame_ff <= sof_frame;
    end
  end

  a_frame_load: assert property (@(posedge hclk) disable iff (!hresetn)
    sof_rx |=> frame_ff == $past(sof_frame)) else $error("frame number not loaded");
  a_setup_disable: assert property (@(posedge hclk) disable iff (!hresetn)
    setup_rx && !host_mode |=> ctrl_ff[uocsr_pkg::CTRL_PKT]) else $error("setup missed");
  a_host_toggle: assert property (@(posedge hclk) disable iff (!hresetn)
    hostt_tog |=> host_logic_rst ##1 !host_logic_rst) else $error("host reset pulse wrong");
  a_err_gate: assert property (@(posedge hclk) disable iff (!hresetn)
    irq_flag_ff[uocsr_pkg::IRQ_ERR] && !irq_en_ff[uocsr_pkg::IRQ_ERR]
    && !irq_flag_ff[uocsr_pkg::IRQ_TRN] && irq_flag_ff[7:4] == 4'h0
    |-> !module_irq_flag) else $error("error leaked to irq");
  a_err_mask: assert property (@(posedge hclk) disable iff (!hresetn)
    (err_flag_ff & err_en_ff) != 8'h00 |=> irq_flag_ff[uocsr_pkg::IRQ_ERR])
    else $error("enabled error not flagged");
  a_eop_len: assert property (@(posedge hclk) disable iff (!hresetn)
    $rose(ls_eop_drive) |-> ls_eop_drive [*8]) else $error("eop too short");
  a_bus_reset: assert property (@(posedge hclk) disable iff (!hresetn)
    wr_en && req_ff.addr == uocsr_pkg::OFS_CTRL && host_mode && wb[uocsr_pkg::CTRL_HOST]
    |=> bus_reset_drive == $past(wb[uocsr_pkg::CTRL_BRST]))
    else $error("bus reset not following host write");
  a_trn_flag: assert property (@(posedge hclk) disable iff (!hresetn)
    trn_done |=> irq_flag_ff[uocsr_pkg::IRQ_TRN]) else $error("transaction flag missed");
endmodule

/* File: shared/uocsr_pkg.sv */
// Purpose: Shared constants and carriers for the USB control/status register slice
// Assumes: 32-bit AHB-Lite register bus, one word per register
// Notes: Register offsets are byte addresses
package uocsr_pkg;
  localparam logic [7:0] OFS_ERR_EN = 8'h00;
  localparam logic [7:0] OFS_STAT = 8'h04;
  localparam logic [7:0] OFS_CTRL = 8'h08;
  localparam logic [7:0] OFS_ADDR = 8'h0C;
  localparam logic [7:0] OFS_FRML = 8'h10;
  localparam logic [7:0] OFS_FRMH = 8'h14;
  localparam logic [7:0] OFS_IRQ_EN = 8'h18;
  localparam logic [7:0] OFS_IRQ_FLAG = 8'h1C;
  localparam logic [7:0] OFS_ERR_FLAG = 8'h20;
  localparam logic [7:0] OFS_MASK = 8'hFC;

  localparam int CTRL_J = 7;
  localparam int CTRL_SE0 = 6;
  localparam int CTRL_PKT = 5;
  localparam int CTRL_BRST = 4;
  localparam int CTRL_HOST = 3;
  localparam int CTRL_RES = 2;
  localparam int CTRL_PPRST = 1;
  localparam int CTRL_ON = 0;
  localparam int ERR_TOKCRC = 1;
  localparam int IRQ_ERR = 1;
  localparam int IRQ_TRN = 3;

  localparam int FIFO_DEPTH = 4;
  localparam int FRAME_W = 11;
  localparam int FRML_W = 8;
  localparam int FRMH_W = 3;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] HSIZE_WORD = 3'h2;
  localparam logic [7:0] BYTE_ZERO = 8'h00;

  localparam int CLK_HZ = 25000000;
  localparam int SOF_PERIOD_US = 1000;
  localparam int SOF_CYCLES = (CLK_HZ / 1000000) * SOF_PERIOD_US;
  localparam int LS_EOP_NS = 1330;
  localparam int LS_EOP_CYCLES = (LS_EOP_NS + 39) / 40;

  typedef struct packed {
    logic [3:0] endpoint;
    logic is_tx;
    logic odd_bank;
  } uocsr_stat_t;

  typedef struct packed {
    logic [1:0] htrans;
    logic [7:0] addr;
    logic write;
    logic ok_size;
  } uocsr_req_t;
endpackage

/* File: tb/uocsr_link_model.sv */
// Purpose: Link engine model that feeds events and live line states to the register slice
// Assumes: All outputs change right after a rising edge of hclk
// Notes: Qualified buses show the inverse of their last value once the pulse is over
module uocsr_link_model (
  input wire logic hclk,
  output logic [7:0] err_events,
  output logic trn_done,
  output uocsr_pkg::uocsr_stat_t trn_stat,
  output logic setup_rx,
  output logic token_active,
  output logic sof_rx,
  output logic [10:0] sof_frame,
  output logic line_j,
  output logic line_se0
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    err_events = 8'h00;
    trn_done = 1'b0;
    trn_stat = '0;
    setup_rx = 1'b0;
    token_active = 1'b0;
    sof_rx = 1'b0;
    sof_frame = 11'h000;
    line_j = 1'b0;
    line_se0 = 1'b0;
  end

  // One-cycle event pulse; status and frame are only meaningful with their strobe
  task automatic ev(input logic [7:0] err, input logic trn, input logic [5:0] st,
                    input logic setup, input logic sof, input logic [10:0] fr);
    @(posedge hclk);
    err_events <= err;
    trn_done <= trn;
    trn_stat <= uocsr_pkg::uocsr_stat_t'(st);
    setup_rx <= setup;
    sof_rx <= sof;
    sof_frame <= fr;
    @(posedge hclk);
    err_events <= 8'h00;
    trn_done <= 1'b0;
    trn_stat <= uocsr_pkg::uocsr_stat_t'(~st);
    setup_rx <= 1'b0;
    sof_rx <= 1'b0;
    sof_frame <= ~fr;
  endtask

  task automatic lines(input logic j, input logic se0, input logic tok);
    @(posedge hclk);
    line_j <= j;
    line_se0 <= se0;
    token_active <= tok;
  endtask
endmodule

/* File: tb/usb_otg_control_status_regs_tb.sv */
// Purpose: Self-checking bench for the USB control/status register slice
// Assumes: Zero-wait AHB-Lite slave; link events come from the partner model
// Notes: Start-of-frame period shortened to 50 cycles
module usb_otg_control_status_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int SOFN = 50;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [7:0] err_events;
  logic trn_done, setup_rx, token_active, sof_rx, line_j, line_se0;
  uocsr_pkg::uocsr_stat_t trn_stat;
  logic [10:0] sof_frame;
  logic module_irq_flag, module_on, host_logic_rst, bus_reset_drive, resume_drive;
  logic ls_eop_drive, pingpong_pointer_reset, packet_proc_disable, sof_send;
  logic next_token_low_speed, stat_fifo_full;
  logic [6:0] function_address;
  int err_count, samples_checked, cyc, sof_last, sof_gap, eop_len, rst_cnt, c;

  uocsr_top #(.SOF_CYCLES(SOFN)) i_dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
    .hsize, .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .err_events, .trn_done,
    .trn_stat, .setup_rx, .token_active, .sof_rx, .sof_frame, .line_j, .line_se0,
    .module_irq_flag, .module_on, .host_logic_rst, .bus_reset_drive, .resume_drive,
    .ls_eop_drive, .pingpong_pointer_reset, .packet_proc_disable, .sof_send,
    .next_token_low_speed, .function_address, .stat_fifo_full);

  uocsr_link_model i_link (.hclk, .err_events, .trn_done, .trn_stat, .setup_rx,
    .token_active, .sof_rx, .sof_frame, .line_j, .line_se0);

  initial begin
    hclk = 1'b0;
    forever #20 hclk = ~hclk;
  end

  // Interval between frame-start pulses, end-of-packet length, host reset pulses
  always @(posedge hclk) begin
    cyc++;
    if (sof_send === 1'b1) begin
      sof_gap = cyc - sof_last;
      sof_last = cyc;
    end
    if (ls_eop_drive === 1'b1) eop_len++;
    if (host_logic_rst === 1'b1) rst_cnt++;
  end

  task chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    htrans <= uocsr_pkg::HTRANS_NONSEQ;
    hwrite <= w;
    hsize <= uocsr_pkg::HSIZE_WORD;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask

  task rdc(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h00000000);
    chk(rd, exp);
  endtask

  task st;
    @(posedge hclk);
    #1;
  endtask

  task final_report;
    $display("checks=%0d errors=%0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  initial begin
    #(40 * 20000);
    err_count++;
    final_report;
  end

  initial begin
    {hresetn, hsel, hwrite, haddr, hwdata, htrans, hsize} = '0;
    {err_count, samples_checked, cyc, sof_last, sof_gap, eop_len, rst_cnt} = '0;
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    // Reset values of every register plus one unmapped word
    for (int i = 0; i < 10; i++) rdc(8'(4 * i), 32'h00000000);
    chk({hreadyout, hresp}, 32'h00000002);
    wr(uocsr_pkg::OFS_ERR_EN, 32'hFFFFFFA5);
    rdc(uocsr_pkg::OFS_ERR_EN, 32'h000000A5);
    wr(uocsr_pkg::OFS_ADDR, 32'h00000083);
    st;
    chk({next_token_low_speed, function_address}, 32'h83);
    rdc(uocsr_pkg::OFS_ADDR, 32'h00000083);
    wr(uocsr_pkg::OFS_FRML, 32'h00000055);
    rdc(uocsr_pkg::OFS_FRML, 32'h00000000);
    // Error gating: per-source enable and general enable
    wr(uocsr_pkg::OFS_ERR_EN, 32'h00000002);
    wr(uocsr_pkg::OFS_IRQ_EN, 32'h00000000);
    i_link.ev(8'h02, 1'b0, 6'h00, 1'b0, 1'b0, 11'h000);
    st;
    chk(module_irq_flag, 1'b0);
    wr(uocsr_pkg::OFS_IRQ_EN, 32'h00000002);
    st;
    chk(module_irq_flag, 1'b1);
    wr(uocsr_pkg::OFS_ERR_FLAG, 32'h000000FF);
    wr(uocsr_pkg::OFS_ERR_EN, 32'h0000007D);
    i_link.ev(8'h02, 1'b0, 6'h00, 1'b0, 1'b0, 11'h000);
    st;
    chk(module_irq_flag, 1'b0);
    i_link.ev(8'h01, 1'b0, 6'h00, 1'b0, 1'b0, 11'h000);
    st;
    chk(module_irq_flag, 1'b1);
    wr(uocsr_pkg::OFS_ERR_FLAG, 32'h000000FF);
    wr(uocsr_pkg::OFS_IRQ_EN, 32'h00000000);
    // Five completions into a four-deep queue; the fifth is dropped
    for (int i = 0; i < 5; i++) begin
      i_link.ev(8'h00, 1'b1, {4'(15 - 3 * i), i[0], ~i[0]}, 1'b0, 1'b0, 11'h000);
    end
    st;
    chk(stat_fifo_full, 1'b1);
    for (int i = 0; i < 4; i++) begin
      rdc(uocsr_pkg::OFS_IRQ_FLAG, 32'h00000008);
      rdc(uocsr_pkg::OFS_STAT, {24'h0, 4'(15 - 3 * i), i[0], ~i[0], 2'b00});
      wr(uocsr_pkg::OFS_IRQ_FLAG, 32'h00000008);
    end
    rdc(uocsr_pkg::OFS_IRQ_FLAG, 32'h00000000);
    chk(stat_fifo_full, 1'b0);
    // Live bus line flags
    i_link.lines(1'b1, 1'b0, 1'b0);
    rdc(uocsr_pkg::OFS_CTRL, 32'h00000080);
    i_link.lines(1'b0, 1'b1, 1'b0);
    rdc(uocsr_pkg::OFS_CTRL, 32'h00000040);
    i_link.lines(1'b0, 1'b0, 1'b0);
    // Device mode: enable, pointer reset, bus reset ignored, SETUP stops processing
    wr(uocsr_pkg::OFS_CTRL, 32'h00000013);
    st;
    chk({module_on, bus_reset_drive, pingpong_pointer_reset}, 3'b101);
    i_link.ev(8'h00, 1'b0, 6'h00, 1'b1, 1'b0, 11'h000);
    st;
    chk(packet_proc_disable, 1'b1);
    rdc(uocsr_pkg::OFS_CTRL, 32'h00000033);
    wr(uocsr_pkg::OFS_CTRL, 32'h00000000);
    st;
    chk(packet_proc_disable, 1'b0);
    // Host mode
    wr(uocsr_pkg::OFS_CTRL, 32'h00000008);
    repeat (3) st;
    chk(rst_cnt, 1);
    i_link.lines(1'b0, 1'b0, 1'b1);
    rdc(uocsr_pkg::OFS_CTRL, 32'h00000028);
    i_link.lines(1'b0, 1'b0, 1'b0);
    rdc(uocsr_pkg::OFS_CTRL, 32'h00000008);
    wr(uocsr_pkg::OFS_CTRL, 32'h00000018);
    st;
    chk(bus_reset_drive, 1'b1);
    wr(uocsr_pkg::OFS_CTRL, 32'h00000008);
    st;
    chk(bus_reset_drive, 1'b0);
    wr(uocsr_pkg::OFS_CTRL, 32'h00000009);
    st;
    chk(module_on, 1'b0);
    repeat (2 * SOFN + 5) st;
    chk(sof_gap, SOFN);
    wr(uocsr_pkg::OFS_CTRL, 32'h00000008);
    st;
    c = sof_last;
    repeat (SOFN + 5) st;
    chk(sof_last, c);
    // Resume held only briefly, far shorter than the real wake-up hold
    wr(uocsr_pkg::OFS_CTRL, 32'h0000000C);
    st;
    chk(resume_drive, 1'b1);
    eop_len = 0;
    wr(uocsr_pkg::OFS_CTRL, 32'h00000008);
    repeat (40) st;
    chk(eop_len, uocsr_pkg::LS_EOP_CYCLES);
    wr(uocsr_pkg::OFS_CTRL, 32'h00000004);
    eop_len = 0;
    wr(uocsr_pkg::OFS_CTRL, 32'h00000000);
    repeat (40) st;
    chk(eop_len, 0);
    chk(rst_cnt, 2);
    // Received frame number split over two registers
    i_link.ev(8'h00, 1'b0, 6'h00, 1'b0, 1'b1, 11'h5A3);
    rdc(uocsr_pkg::OFS_FRML, 32'h000000A3);
    rdc(uocsr_pkg::OFS_FRMH, 32'h00000005);
    final_report;
  end
endmodule
